// >>> design/mbwh_top.sv
// Slave handler for the write-multiple-coils and write-multiple-registers queries.
// Assumes framed bytes from a receiver, rx_end at the silent gap, and a byte transmitter.
`timescale 1ns/100ps
`default_nettype none
`include "mbwh_consts.svh"

module mbwh_top
    import mbwh_pkg::*;
#(
    parameter int STAGE_DEPTH = 32,
    parameter int STAGE_AW    = 5,
    parameter int NUM_TERM    = 7
) (
    // Clock and reset.
    input  wire logic                clk,
    input  wire logic                arst_n,
    // Received bytes.
    input  wire logic                rx_valid,
    input  wire logic [7:0]          rx_data,
    input  wire logic                rx_end,
    // Station address.
    input  wire logic [7:0]          slave_addr,
    // Transmitted bytes.
    output logic                     tx_valid,
    output logic      [7:0]          tx_data,
    input  wire logic                tx_ready,
    // Terminals.
    input  wire logic [NUM_TERM-1:0] term_in,
    output logic      [NUM_TERM-1:0] term_func,
    output logic      [NUM_TERM-1:0] terminal_input_monitor,
    // Holding register contents.
    output logic      [31:0]         accel_time_motor1
);
    mbwh_state_t state_r, state_nxt;
    logic [5:0]  rx_pos_r;
    logic [7:0]  rx_addr_r, rx_fc_r, rx_bc_r;
    logic [15:0] rx_start_r, rx_cnt_r;
    logic [15:0] rx_crc, tx_crc;
    logic        exc_r, bcast_r;
    logic [7:0]  exc_code_r;
    logic [5:0]  cm_idx_r, cm_total_r, cm_byte_r;
    logic        cm_vld_r;
    logic [7:0]  stage_rd;
    logic [2:0]  tx_idx_r;
    logic [NUM_TERM-1:0] coil_r, coil_nxt;
    logic [31:0] accel_r;

    logic        rx_take, tx_take, crc_ok, addressed, is_coil, is_reg;
    logic        cnt_bad, len_bad, cm_issue, cm_done;
    logic [15:0] coil_bytes, first_num;
    logic [7:0]  hdr_byte;
    logic [2:0]  tx_len;

    assign rx_take   = (state_r == S_RECV) && rx_valid;
    assign tx_take   = tx_valid && tx_ready;
    assign first_num = rx_start_r + `MBWH_NUM_OFFSET;

    // Frame screening, evaluated in the check state.
    always_comb begin
        crc_ok     = (rx_crc == 16'h0000) && (rx_pos_r >= `MBWH_MIN_FRAME);
        addressed  = (rx_addr_r == slave_addr) || (rx_addr_r == `MBWH_BCAST_ADDR);
        is_coil    = (rx_fc_r == `MBWH_FC_COILS);
        is_reg     = (rx_fc_r == `MBWH_FC_REGS);
        coil_bytes = (rx_cnt_r + 16'h0007) >> 3;
        cnt_bad    = 1'b0;
        if (is_coil) begin
            cnt_bad = (rx_cnt_r == 16'h0000) || (rx_cnt_r > `MBWH_MAX_COILS)
                   || ({8'h00, rx_bc_r} < coil_bytes)
                   || (rx_bc_r > `MBWH_MAX_COIL_BYTES);
        end else if (is_reg) begin
            cnt_bad = (rx_cnt_r == 16'h0000) || (rx_cnt_r > `MBWH_MAX_REGS)
                   || ({8'h00, rx_bc_r} != {rx_cnt_r[14:0], 1'b0});
        end
        len_bad = ({3'h0, rx_pos_r} != ({1'b0, rx_bc_r} + `MBWH_FRAME_EXTRA));
    end

    assign cm_issue = (state_r == S_COMMIT) && (cm_idx_r < cm_total_r);
    assign cm_done  = (state_r == S_COMMIT) && !cm_issue && !cm_vld_r;
    assign tx_len   = exc_r ? `MBWH_EXC_LEN : `MBWH_ECHO_LEN;

    // Header bytes of the reply: echo or exception.
    always_comb begin
        unique case (tx_idx_r)
            3'h0:    hdr_byte = rx_addr_r;
            3'h1:    hdr_byte = exc_r ? (rx_fc_r | `MBWH_FC_EXC_FLAG) : rx_fc_r;
            3'h2:    hdr_byte = exc_r ? exc_code_r : rx_start_r[15:8];
            3'h3:    hdr_byte = rx_start_r[7:0];
            3'h4:    hdr_byte = rx_cnt_r[15:8];
            default: hdr_byte = rx_cnt_r[7:0];
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            S_RECV: begin
                if (rx_end && (rx_pos_r != 6'h00)) begin
                    state_nxt = S_CHECK;
                end
            end
            S_CHECK: begin
                if (!crc_ok || !addressed) begin
                    state_nxt = S_RECV;
                end else if (!is_coil && !is_reg || cnt_bad || len_bad) begin
                    state_nxt = (rx_addr_r == `MBWH_BCAST_ADDR) ? S_RECV : S_TX_HDR;
                end else begin
                    state_nxt = S_COMMIT;
                end
            end
            S_COMMIT: begin
                if (cm_done) begin
                    state_nxt = bcast_r ? S_RECV : S_TX_HDR;
                end
            end
            S_TX_HDR: begin
                if (tx_take && (tx_idx_r == tx_len - 3'h1)) begin
                    state_nxt = S_TX_GAP;
                end
            end
            S_TX_GAP: state_nxt = S_TX_CRL;
            S_TX_CRL: begin
                if (tx_take) begin
                    state_nxt = S_TX_CRH;
                end
            end
            S_TX_CRH: begin
                if (tx_take) begin
                    state_nxt = S_RECV;
                end
            end
            default: state_nxt = S_RECV;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= S_RECV;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Query field capture; data bytes go to the staging memory.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_pos_r   <= 6'h00;
            rx_addr_r  <= 8'h00;
            rx_fc_r    <= 8'h00;
            rx_bc_r    <= 8'h00;
            rx_start_r <= 16'h0000;
            rx_cnt_r   <= 16'h0000;
        end else if (state_r != S_RECV) begin
            if (state_nxt == S_RECV) begin
                rx_pos_r <= 6'h00;
            end
        end else if (rx_take) begin
            if (rx_pos_r != 6'h3F) begin
                rx_pos_r <= rx_pos_r + 6'h01;
            end
            unique case (rx_pos_r)
                6'h00:   rx_addr_r <= rx_data;
                6'h01:   rx_fc_r <= rx_data;
                6'h02:   rx_start_r[15:8] <= rx_data;
                6'h03:   rx_start_r[7:0] <= rx_data;
                6'h04:   rx_cnt_r[15:8] <= rx_data;
                6'h05:   rx_cnt_r[7:0] <= rx_data;
                6'h06:   rx_bc_r <= rx_data;
                default: ;
            endcase
        end
    end

    mbwh_crc16 u_rx_crc (
        .clk    (clk),
        .arst_n (arst_n),
        .clr    (state_r != S_RECV),
        .en     (rx_take),
        .data   (rx_data),
        .crc    (rx_crc)
    );

    mbwh_crc16 u_tx_crc (
        .clk    (clk),
        .arst_n (arst_n),
        .clr    (state_r == S_CHECK),
        .en     (tx_take && (state_r == S_TX_HDR)),
        .data   (tx_data),
        .crc    (tx_crc)
    );

    logic [5:0] stage_wofs;
    assign stage_wofs = rx_pos_r - 6'(`MBWH_HDR_BYTES);

    mbwh_stage_mem #(
        .WIDTH (8),
        .DEPTH (STAGE_DEPTH),
        .AW    (STAGE_AW)
    ) u_stage (
        .clk   (clk),
        .we    (rx_take && (rx_pos_r >= 6'(`MBWH_HDR_BYTES))
                && (stage_wofs < 6'(STAGE_DEPTH))),
        .waddr (stage_wofs[STAGE_AW-1:0]),
        .wdata (rx_data),
        .raddr (cm_idx_r[STAGE_AW-1:0]),
        .rdata (stage_rd)
    );

    // Outcome of the check and commit walk over staged bytes.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            exc_r      <= 1'b0;
            exc_code_r <= 8'h00;
            bcast_r    <= 1'b0;
            cm_idx_r   <= 6'h00;
            cm_total_r <= 6'h00;
            cm_byte_r  <= 6'h00;
            cm_vld_r   <= 1'b0;
        end else begin
            cm_vld_r  <= cm_issue;
            cm_byte_r <= cm_idx_r;
            if (cm_issue) begin
                cm_idx_r <= cm_idx_r + 6'h01;
            end
            if (state_r == S_CHECK) begin
                bcast_r    <= (rx_addr_r == `MBWH_BCAST_ADDR);
                exc_r      <= !is_coil && !is_reg || cnt_bad || len_bad;
                exc_code_r <= (!is_coil && !is_reg) ? `MBWH_EXC_ILL_FUNC : `MBWH_EXC_DATA;
                cm_idx_r   <= 6'h00;
                cm_total_r <= is_coil ? coil_bytes[5:0] : rx_bc_r[5:0];
            end
        end
    end

    // Coil bits from one staged byte, lowest bit to the first coil.
    logic [15:0] bit_num, coil_num;
    always_comb begin
        coil_nxt = coil_r;
        bit_num  = 16'h0000;
        coil_num = 16'h0000;
        if (cm_vld_r && is_coil) begin
            for (int j = 0; j < 8; j++) begin
                bit_num  = {7'h00, cm_byte_r, 3'h0} + 16'(j);
                coil_num = first_num + bit_num;
                if ((bit_num < rx_cnt_r) && (coil_num >= `MBWH_COIL_FIRST)
                        && (coil_num <= `MBWH_COIL_LAST)) begin
                    coil_nxt[3'(coil_num - `MBWH_COIL_FIRST)] = stage_rd[j];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            coil_r <= '0;
        end else begin
            coil_r <= coil_nxt;
        end
    end

    // Holding register pair; high half at the lower number, high byte first.
    logic [15:0] word_num;
    assign word_num = first_num + {11'h000, cm_byte_r[5:1]};

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            accel_r <= `MBWH_ACCEL_RESET;
        end else if (cm_vld_r && is_reg) begin
            if (word_num == `MBWH_ACCEL_HI_REG) begin
                if (!cm_byte_r[0]) accel_r[31:24] <= stage_rd;
                else accel_r[23:16] <= stage_rd;
            end else if (word_num == `MBWH_ACCEL_LO_REG) begin
                if (!cm_byte_r[0]) accel_r[15:8] <= stage_rd;
                else accel_r[7:0] <= stage_rd;
            end
        end
    end

    // Transmit byte register.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_valid <= 1'b0;
            tx_data  <= 8'h00;
            tx_idx_r <= 3'h0;
        end else begin
            if (state_nxt == S_TX_HDR && state_r != S_TX_HDR) begin
                tx_valid <= 1'b1;
                tx_data  <= rx_addr_r;
                tx_idx_r <= 3'h0;
            end else if (state_r == S_TX_HDR && tx_take) begin
                tx_idx_r <= tx_idx_r + 3'h1;
                tx_valid <= (state_nxt == S_TX_HDR);
                unique case (tx_idx_r)
                    3'h0:    tx_data <= exc_r ? (rx_fc_r | `MBWH_FC_EXC_FLAG) : rx_fc_r;
                    3'h1:    tx_data <= exc_r ? exc_code_r : rx_start_r[15:8];
                    3'h2:    tx_data <= rx_start_r[7:0];
                    3'h3:    tx_data <= rx_cnt_r[15:8];
                    default: tx_data <= rx_cnt_r[7:0];
                endcase
            end else if (state_r == S_TX_GAP) begin
                tx_valid <= 1'b1;
                tx_data  <= tx_crc[7:0];
            end else if (state_r == S_TX_CRL && tx_take) begin
                tx_data <= tx_crc[15:8];
            end else if (state_r == S_TX_CRH && tx_take) begin
                tx_valid <= 1'b0;
            end
        end
    end

    // Terminal outputs.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            term_func              <= '0;
            terminal_input_monitor <= '0;
        end else begin
            term_func              <= term_in | coil_r;
            terminal_input_monitor <= term_in;
        end
    end

    assign accel_time_motor1 = accel_r;

    a_term_or: assert property (@(posedge clk) disable iff (!arst_n)
        1'b1 |=> term_func == ($past(term_in) | $past(coil_r)))
        else $error("Terminal function is not input OR coil.");
    a_monitor_phys: assert property (@(posedge clk) disable iff (!arst_n)
        $changed(coil_r) && $stable(term_in) |=> $stable(terminal_input_monitor))
        else $error("Monitor follows written coils.");
    a_bcast_silent: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == S_CHECK && rx_addr_r == `MBWH_BCAST_ADDR |=> !tx_valid [*8])
        else $error("Broadcast query got a reply.");
    a_drop_silent: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == S_CHECK && (!crc_ok || !addressed) |=> state_r == S_RECV && !tx_valid)
        else $error("Bad frame was not dropped.");
    a_coil_limit: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == S_CHECK && crc_ok && rx_addr_r == slave_addr && is_coil
        && rx_cnt_r > `MBWH_MAX_COILS |=> exc_r && exc_code_r == `MBWH_EXC_DATA
        && state_r == S_TX_HDR)
        else $error("Coil limit not refused with 03h.");
    a_reg_limit: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == S_CHECK && crc_ok && rx_addr_r == slave_addr && is_reg
        && rx_cnt_r > `MBWH_MAX_REGS |=> exc_r && exc_code_r == `MBWH_EXC_DATA)
        else $error("Register limit not refused with 03h.");
    a_byte_count: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == S_CHECK && crc_ok && is_reg
        && {8'h00, rx_bc_r} != {rx_cnt_r[14:0], 1'b0} |=> exc_r)
        else $error("Register byte count mismatch accepted.");
    a_exc_code: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == S_TX_HDR && exc_r && tx_idx_r == 3'h1 && tx_valid
        |-> tx_data == (rx_fc_r | `MBWH_FC_EXC_FLAG))
        else $error("Exception function code lacks 80h.");
    a_echo_start: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == S_TX_HDR && !exc_r && tx_idx_r == 3'h2 && tx_valid
        |-> tx_data == rx_start_r[15:8])
        else $error("Echo start number wrong.");
    a_hdr_bytes: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == S_TX_HDR && tx_valid |-> tx_data == hdr_byte)
        else $error("Reply header byte out of order.");
    a_accel_high: assert property (@(posedge clk) disable iff (!arst_n)
        cm_vld_r && is_reg && word_num == `MBWH_ACCEL_HI_REG && !cm_byte_r[0]
        |=> accel_time_motor1[31:24] == $past(stage_rd))
        else $error("Acceleration high byte not stored.");
endmodule
`default_nettype wire

// >>> design/mbwh_consts.svh
// Constants for the multiple-write handler: field codes, limits and register numbers.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef MBWH_CONSTS_SVH
`define MBWH_CONSTS_SVH

`define MBWH_FC_COILS     8'h0F
`define MBWH_FC_REGS      8'h10
`define MBWH_FC_EXC_FLAG  8'h80
`define MBWH_EXC_ILL_FUNC 8'h01
`define MBWH_EXC_DATA     8'h03
`define MBWH_BCAST_ADDR   8'h00
`define MBWH_MAX_COILS    16'h0020
`define MBWH_MAX_REGS     16'h0010
`define MBWH_MAX_COIL_BYTES 8'h04
`define MBWH_NUM_OFFSET   16'h0001
`define MBWH_COIL_FIRST   16'h0007
`define MBWH_COIL_LAST    16'h000D
`define MBWH_ACCEL_HI_REG 16'h1103
`define MBWH_ACCEL_LO_REG 16'h1104
`define MBWH_ACCEL_RESET  32'h0000_0000
`define MBWH_HDR_BYTES    9'h007
`define MBWH_FRAME_EXTRA  9'h009
`define MBWH_MIN_FRAME    6'h04
`define MBWH_ECHO_LEN     3'h6
`define MBWH_EXC_LEN      3'h3
`define MBWH_CRC_INIT     16'hFFFF
`define MBWH_CRC_POLY     16'hA001

`endif

// >>> design/mbwh_pkg.sv
// Types shared by the multiple-write handler.
// Assumes no other package.
package mbwh_pkg;

    typedef enum logic [2:0] {
        S_RECV   = 3'h0,
        S_CHECK  = 3'h1,
        S_COMMIT = 3'h3,
        S_TX_HDR = 3'h2,
        S_TX_GAP = 3'h6,
        S_TX_CRL = 3'h7,
        S_TX_CRH = 3'h5
    } mbwh_state_t;

endpackage

// >>> design/mbwh_crc16.sv
// Byte-serial CRC-16 register with the reflected serial-line polynomial.
// Assumes one byte per enabled cycle; clr restarts the sum.
`timescale 1ns/100ps
`default_nettype none
`include "mbwh_consts.svh"

module mbwh_crc16 (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Byte input.
    input  wire logic        clr,
    input  wire logic        en,
    input  wire logic [7:0]  data,
    // Running sum.
    output logic      [15:0] crc
);
    logic [15:0] crc_nxt;

    always_comb begin
        crc_nxt = crc ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            crc_nxt = crc_nxt[0] ? ((crc_nxt >> 1) ^ `MBWH_CRC_POLY) : (crc_nxt >> 1);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            crc <= `MBWH_CRC_INIT;
        end else if (clr) begin
            crc <= `MBWH_CRC_INIT;
        end else if (en) begin
            crc <= crc_nxt;
        end
    end
endmodule
`default_nettype wire

// >>> design/mbwh_stage_mem.sv
// Staging memory that holds the data bytes of a query until its check is done.
// Assumes one write and one read port; read data appear one cycle after the address.
`timescale 1ns/100ps
`default_nettype none

module mbwh_stage_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    // Clock.
    input  wire logic             clk,
    // Write port.
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    // Read port.
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

// >>> testbench/mbwh_master.sv
// Serial-line master model that sends queries to the handler and gathers its replies.
// Assumes the bench calls its tasks from one process, one frame at a time.
`timescale 1ns/100ps
`default_nettype none

module mbwh_master (
    // Clock.
    input  wire logic       clk,
    // Query bytes to the slave.
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_end,
    // Reply bytes from the slave.
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready
);
    logic       slow;
    logic [7:0] resp[$];

    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        rx_end   = 1'b0;
        tx_ready = 1'b1;
        slow     = 1'b0;
    end

    // In slow mode a reply byte is taken only every other cycle.
    always @(posedge clk) begin
        if (tx_valid && tx_ready) begin
            resp.push_back(tx_data);
        end
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end

    // The line shows the inverted byte between strobes, never the last value.
    task automatic put_byte(input logic [7:0] b);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_data  <= b;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_data  <= ~b;
    endtask

    task automatic end_frame();
        @(posedge clk);
        rx_end <= 1'b1;
        @(posedge clk);
        rx_end <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> testbench/modbus_multi_write_handler_bench.sv
// Self-checking bench for the multiple-write handler with a serial-line master model.
// Assumes the handler answers within a few hundred cycles of the end of a query.
`timescale 1ns/100ps
`default_nettype none

module modbus_multi_write_handler_bench;
    logic        clk;
    logic        arst_n;
    logic        rx_valid;
    logic        rx_end;
    logic        tx_valid;
    logic        tx_ready;
    logic [7:0]  rx_data;
    logic [7:0]  tx_data;
    logic [7:0]  slave_addr;
    logic [6:0]  term_in;
    logic [6:0]  term_func;
    logic [6:0]  mon;
    logic [31:0] accel;
    int          error_cnt;
    int          checked;
    logic [7:0]  fr[$];
    logic [7:0]  ex[$];

    mbwh_top dut (
        .clk(clk), .arst_n(arst_n), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_end(rx_end), .slave_addr(slave_addr), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .term_in(term_in),
        .term_func(term_func), .terminal_input_monitor(mon), .accel_time_motor1(accel)
    );

    mbwh_master m (
        .clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Appends the line checksum, low byte first.
    task automatic seal(ref logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int k = 0; k < 8; k++) begin
                c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
            end
        end
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
    endtask

    // Sends fr, compares the reply with ex (silence if empty) and the register.
    task automatic run(input logic bad, input logic [31:0] acc);
        int n;
        seal(fr);
        if (ex.size() > 0) begin
            seal(ex);
        end
        if (bad) begin
            fr[fr.size()-1] = ~fr[fr.size()-1];
        end
        m.resp.delete();
        foreach (fr[i]) begin
            m.put_byte(fr[i]);
        end
        m.end_frame();
        n = 0;
        while (m.resp.size() < ex.size() && n < 400) begin
            @(posedge clk);
            n++;
        end
        repeat (60) @(posedge clk);
        chk(m.resp.size(), ex.size());
        foreach (ex[i]) begin
            if (i < m.resp.size()) begin
                chk(m.resp[i], ex[i]);
            end
        end
        chk(accel, acc);
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        complete_run();
    end

    initial begin
        arst_n     = 1'b0;
        slave_addr = 8'h01;
        term_in    = 7'h00;
        error_cnt  = 0;
        checked    = 0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        chk(accel, 32'h0000_0000);
        chk(term_func, 7'h00);
        fr = '{8'h01, 8'h0F, 8'h00, 8'h06, 8'h00, 8'h07, 8'h02, 8'h17, 8'h00};
        ex = '{8'h01, 8'h0F, 8'h00, 8'h06, 8'h00, 8'h07};
        run(1'b0, 32'h0000_0000);
        chk(term_func, 7'h17);
        chk(mon, 7'h00);
        term_in <= 7'h28;
        repeat (3) @(posedge clk);
        chk(term_func, 7'h3F);
        chk(mon, 7'h28);
        m.slow = 1'b1;
        fr = '{8'h01, 8'h0F, 8'h00, 8'h08, 8'h00, 8'h02, 8'h02, 8'h00, 8'h00};
        ex = '{8'h01, 8'h0F, 8'h00, 8'h08, 8'h00, 8'h02};
        run(1'b0, 32'h0000_0000);
        chk(term_func, 7'h3B);
        m.slow = 1'b0;
        fr = '{8'h01, 8'h0F, 8'h00, 8'h06, 8'h00, 8'h20, 8'h04,
               8'hFF, 8'hFF, 8'hFF, 8'hFF};
        ex = '{8'h01, 8'h0F, 8'h00, 8'h06, 8'h00, 8'h20};
        run(1'b0, 32'h0000_0000);
        chk(term_func, 7'h7F);
        // Thirty-three coils need five bytes, padded to an even six.
        fr = '{8'h01, 8'h0F, 8'h00, 8'h06, 8'h00, 8'h21, 8'h06};
        repeat (6) fr.push_back(8'h00);
        ex = '{8'h01, 8'h8F, 8'h03};
        run(1'b0, 32'h0000_0000);
        chk(term_func, 7'h7F);
        fr = '{8'h01, 8'h10, 8'h11, 8'h02, 8'h00, 8'h02, 8'h04,
               8'h00, 8'h12, 8'h03, 8'hE8};
        ex = '{8'h01, 8'h10, 8'h11, 8'h02, 8'h00, 8'h02};
        run(1'b0, 32'h0012_03E8);
        fr = '{8'h01, 8'h10, 8'h11, 8'h02, 8'h00, 8'h10, 8'h20,
               8'hAB, 8'hCD, 8'h12, 8'h34};
        repeat (28) fr.push_back(8'h00);
        ex = '{8'h01, 8'h10, 8'h11, 8'h02, 8'h00, 8'h10};
        run(1'b0, 32'hABCD_1234);
        fr = '{8'h01, 8'h10, 8'h11, 8'h02, 8'h00, 8'h11, 8'h22};
        repeat (34) fr.push_back(8'h00);
        ex = '{8'h01, 8'h90, 8'h03};
        run(1'b0, 32'hABCD_1234);
        fr = '{8'h01, 8'h10, 8'h11, 8'h02, 8'h00, 8'h02, 8'h03, 8'h00, 8'h00, 8'h01};
        ex = '{8'h01, 8'h90, 8'h03};
        run(1'b0, 32'hABCD_1234);
        // A function outside the two writes is refused with code 01h.
        fr = '{8'h01, 8'h05, 8'h00, 8'h06, 8'hFF, 8'h00};
        ex = '{8'h01, 8'h85, 8'h01};
        run(1'b0, 32'hABCD_1234);
        fr = '{8'h00, 8'h10, 8'h11, 8'h02, 8'h00, 8'h02, 8'h04,
               8'h00, 8'h00, 8'h00, 8'h05};
        ex = {};
        run(1'b0, 32'h0000_0005);
        fr = '{8'h00, 8'h0F, 8'h00, 8'h06, 8'h00, 8'h07, 8'h02, 8'h00, 8'h00};
        run(1'b0, 32'h0000_0005);
        chk(term_func, 7'h28);
        fr = '{8'h01, 8'h10, 8'h11, 8'h02, 8'h00, 8'h02, 8'h04,
               8'h00, 8'h00, 8'h00, 8'h09};
        run(1'b1, 32'h0000_0005);
        fr = '{8'h02, 8'h10, 8'h11, 8'h02, 8'h00, 8'h02, 8'h04,
               8'h00, 8'h00, 8'h00, 8'h09};
        run(1'b0, 32'h0000_0005);
        complete_run();
    end
endmodule
`default_nettype wire
